// ==== srr_pkg.sv ====
// constants for the synthesizer sysref and readback register slice
package srr_pkg;
	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_CTRL = 8'h47;
	localparam logic [7:0] IDX_DIV = 8'h48;
	localparam logic [7:0] IDX_DLY_A = 8'h49;
	localparam logic [7:0] IDX_DLY_B = 8'h4a;
	localparam logic [7:0] IDX_CHANNEL_DIVIDER_SELECT = 8'h4b;
	localparam logic [7:0] IDX_LOCK = 8'h6e;
	localparam logic [7:0] IDX_CAP = 8'h6f;
	localparam logic [7:0] IDX_BIAS = 8'h70;
	localparam logic [7:0] IDX_MODE = 8'h71;
	localparam int NUM_REGS = 9;
	// one-hot select positions
	localparam int SEL_CTRL = 0;
	localparam int SEL_DIV = 1;
	localparam int SEL_DLY_A = 2;
	localparam int SEL_DLY_B = 3;
	localparam int SEL_CHANNEL_DIVIDER_SELECT = 4;
	localparam int SEL_LOCK = 5;
	localparam int SEL_CAP = 6;
	localparam int SEL_BIAS = 7;
	localparam int SEL_MODE = 8;
	// field positions
	localparam int CTRL_REP_LSB = 0;
	localparam int CTRL_MULTI_LSB = 1;
	localparam int DIV_LSB = 0;
	localparam int TRIM_W = 6;
	localparam int TRIM_LO_LSB = 0;
	localparam int TRIM_HI_LSB = 6;
	localparam int BURST_LSB = 12;
	localparam int BURST_W = 4;
	localparam int CHANNEL_DIVIDER_SELECT_LSB = 6;
	localparam int CHANNEL_DIVIDER_SELECT_W = 5;
	localparam int LOCK_LSB = 9;
	localparam int LOCK_W = 2;
	localparam int CORE_LSB = 5;
	localparam int CORE_W = 3;
	localparam int CAP_W = 8;
	localparam int BIAS_W = 9;
	localparam int PINMODE_W = 8;
	// reset values
	localparam logic [10:0] DIV_RST = 11'h001;
	localparam logic [5:0] TRIM_ONE_RST = 6'h3f;
	localparam logic [5:0] TRIM_OTHER_RST = 6'h00;
	localparam logic [3:0] BURST_RST = 4'h0;
	localparam logic [4:0] CHANNEL_DIVIDER_SELECT_RST = 5'h00;
	// pulse generator states
	typedef enum logic [1:0] {
		PG_IDLE = 2'b01,
		PG_BURST = 2'b10
	} srr_pg_state_t;
endpackage : srr_pkg

// ==== srr_pulse_gen.sv ====
// ref_pulse_out sequencer: free-running or request-driven bursts
`timescale 1ns/10ps
module srr_pulse_gen #(
	parameter int DIV_W = 11,
	parameter int CNT_W = 4
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic repeater,
	input wire logic multi,
	input wire logic [CNT_W-1:0] burst_count,
	input wire logic [DIV_W-1:0] divider,
	input wire logic ref_request_pin,
	output logic ref_pulse_out,
	output logic burst_busy
);
	if (DIV_W < 1 || CNT_W < 1) begin : g_chk
		$error("srr_pulse_gen: widths must be positive");
	end

	srr_pkg::srr_pg_state_t state, next_state;
	logic req_q, next_req_q;
	logic busy_q, next_busy_q;
	logic [DIV_W-1:0] div_cnt, next_div_cnt;
	logic [CNT_W-1:0] left, next_left;
	logic next_pulse;
	logic tick;
	logic req_rise;

	// divider zero behaves as one so the tick never stalls
	assign tick = (div_cnt == '0);
	assign req_rise = ref_request_pin && !req_q;
	assign burst_busy = (state == srr_pkg::PG_BURST);

	// sequencer next state
	always_comb begin
		next_state = state;
		next_req_q = ref_request_pin;
		next_busy_q = burst_busy;
		next_left = left;
		next_pulse = 1'b0;
		next_div_cnt = tick ? ((divider == '0) ? '0 : divider - 1'b1) : div_cnt - 1'b1;
		case (state)
			srr_pkg::PG_IDLE: begin
				if (!repeater) begin
					next_pulse = tick;
				end else if (req_rise) begin
					next_left = multi ? burst_count : CNT_W'(1);
					next_div_cnt = '0;
					if (!multi || burst_count != '0) begin
						next_state = srr_pkg::PG_BURST;
					end
				end
			end
			srr_pkg::PG_BURST: begin
				if (tick) begin
					next_pulse = 1'b1;
					next_left = left - 1'b1;
					if (left == CNT_W'(1)) begin
						next_state = srr_pkg::PG_IDLE;
					end
				end
			end
			default: next_state = srr_pkg::PG_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= srr_pkg::PG_IDLE;
			req_q <= 1'b0;
			busy_q <= 1'b0;
			div_cnt <= '0;
			left <= '0;
			ref_pulse_out <= 1'b0;
		end else begin
			state <= next_state;
			req_q <= next_req_q;
			busy_q <= next_busy_q;
			div_cnt <= next_div_cnt;
			left <= next_left;
			ref_pulse_out <= next_pulse;
		end
	end

	// helper: pulses seen in the current burst, and the length expected
	// the last pulse leaves while busy already falls, so one cycle of busy_q covers it
	logic [CNT_W:0] seen;
	logic [CNT_W-1:0] want;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seen <= '0;
			want <= '0;
		end else if (state == srr_pkg::PG_IDLE && next_state == srr_pkg::PG_BURST) begin
			seen <= '0;
			want <= next_left;
		end else if ((burst_busy || busy_q) && ref_pulse_out) begin
			seen <= seen + 1'b1;
		end
	end

	a_req_starts_burst: assert property (@(posedge pclk) disable iff (!presetn)
		(state == srr_pkg::PG_IDLE && repeater && req_rise && (!multi || burst_count != '0))
		|=> burst_busy)
		else $error("request rise did not start a burst");
	a_burst_length: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(burst_busy) |=> (seen == {1'b0, want}))
		else $error("burst emitted the wrong number of pulses");
	c_burst_done: cover property (@(posedge pclk) disable iff (!presetn)
		$fell(burst_busy) && want > CNT_W'(1));
endmodule : srr_pulse_gen

// ==== srr_regs.sv ====
// sysref control and calibration readback registers behind an apb slave
//
// Contract
// - 11-bit sysref divider field, resets to one
// - four 6-bit delay trims; first resets all ones
// - 4-bit burst pulse count, resets to zero
// - 5-bit channel divider select, resets to zero
// - 2-bit lock state readback, four coded values
// - 8-bit calibrated capacitor readback
// - 9-bit calibrated bias current readback
// - mode pins: recal bit 0, modes 1-8
// - repeater mode pulses follow request pin
// - multi-pulse sends burst count per request
//
// Register access over APB is this design's own decision.
`timescale 1ns/10ps
module srr_regs #(
	parameter int DIV_W = 11,
	parameter int BURST_W = 4
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [1:0] lock_state_readback,
	input wire logic [2:0] osc_core_readback,
	input wire logic [7:0] osc_cap_readback,
	input wire logic [8:0] osc_bias_readback,
	input wire logic recal_pin_enable,
	input wire logic [7:0] pin_mode_select,
	input wire logic ref_request_pin,
	output logic [10:0] ref_pulse_divider,
	output logic [5:0] delay_trim_one,
	output logic [5:0] delay_trim_two,
	output logic [5:0] delay_trim_three,
	output logic [5:0] delay_trim_four,
	output logic [3:0] ref_burst_count,
	output logic [4:0] channel_divider_select,
	output logic ref_repeater_select,
	output logic ref_multi_pulse_enable,
	output logic ref_pulse_out,
	output logic burst_busy
);
	// the register layout is fixed; other widths cannot be mapped
	if (DIV_W != 11 || BURST_W != srr_pkg::BURST_W) begin : g_chk
		$error("srr_regs: field widths are fixed by the register layout");
	end

	// one-hot register select from a byte address; unmapped gives zero
	function automatic logic [srr_pkg::NUM_REGS-1:0] srr_decode(input logic [11:0] a);
		logic [srr_pkg::NUM_REGS-1:0] s;
		logic [9:0] idx;
		s = '0;
		idx = a[11:2];
		if (a[1:0] != 2'b00) begin
			s = '0;
		end else if (idx == {2'b00, srr_pkg::IDX_CTRL}) begin
			s[srr_pkg::SEL_CTRL] = 1'b1;
		end else if (idx == {2'b00, srr_pkg::IDX_DIV}) begin
			s[srr_pkg::SEL_DIV] = 1'b1;
		end else if (idx == {2'b00, srr_pkg::IDX_DLY_A}) begin
			s[srr_pkg::SEL_DLY_A] = 1'b1;
		end else if (idx == {2'b00, srr_pkg::IDX_DLY_B}) begin
			s[srr_pkg::SEL_DLY_B] = 1'b1;
		end else if (idx == {2'b00, srr_pkg::IDX_CHANNEL_DIVIDER_SELECT}) begin
			s[srr_pkg::SEL_CHANNEL_DIVIDER_SELECT] = 1'b1;
		end else if (idx == {2'b00, srr_pkg::IDX_LOCK}) begin
			s[srr_pkg::SEL_LOCK] = 1'b1;
		end else if (idx == {2'b00, srr_pkg::IDX_CAP}) begin
			s[srr_pkg::SEL_CAP] = 1'b1;
		end else if (idx == {2'b00, srr_pkg::IDX_BIAS}) begin
			s[srr_pkg::SEL_BIAS] = 1'b1;
		end else if (idx == {2'b00, srr_pkg::IDX_MODE}) begin
			s[srr_pkg::SEL_MODE] = 1'b1;
		end
		return s;
	endfunction : srr_decode

	logic [srr_pkg::NUM_REGS-1:0] sel_w;
	logic [srr_pkg::NUM_REGS-1:0] sel_r;
	logic wr_en;
	logic setup;
	logic next_repeater, next_multi;
	logic [10:0] next_divider;
	logic [5:0] next_trim_one, next_trim_two, next_trim_three, next_trim_four;
	logic [3:0] next_burst;
	logic [4:0] next_channel_divider_select;
	logic [31:0] next_prdata;
	logic next_pslverr;

	// zero wait states: read data is captured during the setup cycle
	assign pready = psel && penable;
	assign setup = psel && !penable;
	assign wr_en = psel && penable && pwrite;
	assign sel_w = srr_decode(paddr);
	assign sel_r = sel_w;

	// writable fields; only defined field bits are stored
	always_comb begin
		next_repeater = ref_repeater_select;
		next_multi = ref_multi_pulse_enable;
		next_divider = ref_pulse_divider;
		next_trim_one = delay_trim_one;
		next_trim_two = delay_trim_two;
		next_trim_three = delay_trim_three;
		next_trim_four = delay_trim_four;
		next_burst = ref_burst_count;
		next_channel_divider_select = channel_divider_select;
		if (wr_en && sel_w[srr_pkg::SEL_CTRL]) begin
			next_repeater = pwdata[srr_pkg::CTRL_REP_LSB];
			next_multi = pwdata[srr_pkg::CTRL_MULTI_LSB];
		end
		if (wr_en && sel_w[srr_pkg::SEL_DIV]) begin
			next_divider = pwdata[srr_pkg::DIV_LSB +: DIV_W];
		end
		if (wr_en && sel_w[srr_pkg::SEL_DLY_A]) begin
			next_trim_one = pwdata[srr_pkg::TRIM_LO_LSB +: srr_pkg::TRIM_W];
			next_trim_two = pwdata[srr_pkg::TRIM_HI_LSB +: srr_pkg::TRIM_W];
		end
		if (wr_en && sel_w[srr_pkg::SEL_DLY_B]) begin
			next_trim_three = pwdata[srr_pkg::TRIM_LO_LSB +: srr_pkg::TRIM_W];
			next_trim_four = pwdata[srr_pkg::TRIM_HI_LSB +: srr_pkg::TRIM_W];
			next_burst = pwdata[srr_pkg::BURST_LSB +: srr_pkg::BURST_W];
		end
		if (wr_en && sel_w[srr_pkg::SEL_CHANNEL_DIVIDER_SELECT]) begin
			next_channel_divider_select = pwdata[srr_pkg::CHANNEL_DIVIDER_SELECT_LSB +: srr_pkg::CHANNEL_DIVIDER_SELECT_W];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ref_repeater_select <= 1'b0;
			ref_multi_pulse_enable <= 1'b0;
			ref_pulse_divider <= srr_pkg::DIV_RST;
			delay_trim_one <= srr_pkg::TRIM_ONE_RST;
			delay_trim_two <= srr_pkg::TRIM_OTHER_RST;
			delay_trim_three <= srr_pkg::TRIM_OTHER_RST;
			delay_trim_four <= srr_pkg::TRIM_OTHER_RST;
			ref_burst_count <= srr_pkg::BURST_RST;
			channel_divider_select <= srr_pkg::CHANNEL_DIVIDER_SELECT_RST;
		end else begin
			ref_repeater_select <= next_repeater;
			ref_multi_pulse_enable <= next_multi;
			ref_pulse_divider <= next_divider;
			delay_trim_one <= next_trim_one;
			delay_trim_two <= next_trim_two;
			delay_trim_three <= next_trim_three;
			delay_trim_four <= next_trim_four;
			ref_burst_count <= next_burst;
			channel_divider_select <= next_channel_divider_select;
		end
	end

	// read mux; unset bits stay zero, status is sampled live at setup
	always_comb begin
		next_prdata = prdata;
		next_pslverr = pslverr;
		if (setup) begin
			next_prdata = '0;
			next_pslverr = (sel_r == '0);
			if (sel_r[srr_pkg::SEL_CTRL]) begin
				next_prdata[srr_pkg::CTRL_REP_LSB] = ref_repeater_select;
				next_prdata[srr_pkg::CTRL_MULTI_LSB] = ref_multi_pulse_enable;
			end else if (sel_r[srr_pkg::SEL_DIV]) begin
				next_prdata[srr_pkg::DIV_LSB +: DIV_W] = ref_pulse_divider;
			end else if (sel_r[srr_pkg::SEL_DLY_A]) begin
				next_prdata[srr_pkg::TRIM_LO_LSB +: srr_pkg::TRIM_W] = delay_trim_one;
				next_prdata[srr_pkg::TRIM_HI_LSB +: srr_pkg::TRIM_W] = delay_trim_two;
			end else if (sel_r[srr_pkg::SEL_DLY_B]) begin
				next_prdata[srr_pkg::TRIM_LO_LSB +: srr_pkg::TRIM_W] = delay_trim_three;
				next_prdata[srr_pkg::TRIM_HI_LSB +: srr_pkg::TRIM_W] = delay_trim_four;
				next_prdata[srr_pkg::BURST_LSB +: srr_pkg::BURST_W] = ref_burst_count;
			end else if (sel_r[srr_pkg::SEL_CHANNEL_DIVIDER_SELECT]) begin
				next_prdata[srr_pkg::CHANNEL_DIVIDER_SELECT_LSB +: srr_pkg::CHANNEL_DIVIDER_SELECT_W] = channel_divider_select;
			end else if (sel_r[srr_pkg::SEL_LOCK]) begin
				next_prdata[srr_pkg::LOCK_LSB +: srr_pkg::LOCK_W] = lock_state_readback;
				next_prdata[srr_pkg::CORE_LSB +: srr_pkg::CORE_W] = osc_core_readback;
			end else if (sel_r[srr_pkg::SEL_CAP]) begin
				next_prdata[srr_pkg::CAP_W-1:0] = osc_cap_readback;
			end else if (sel_r[srr_pkg::SEL_BIAS]) begin
				next_prdata[srr_pkg::BIAS_W-1:0] = osc_bias_readback;
			end else if (sel_r[srr_pkg::SEL_MODE]) begin
				next_prdata[0] = recal_pin_enable;
				next_prdata[srr_pkg::PINMODE_W:1] = pin_mode_select;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
			pslverr <= 1'b0;
		end else begin
			prdata <= next_prdata;
			pslverr <= next_pslverr;
		end
	end

	// pulse sequencer steered by the control fields above
	srr_pulse_gen #(
		.DIV_W(DIV_W),
		.CNT_W(BURST_W)
	) u_pulse (
		.pclk(pclk),
		.presetn(presetn),
		.repeater(ref_repeater_select),
		.multi(ref_multi_pulse_enable),
		.burst_count(ref_burst_count),
		.divider(ref_pulse_divider),
		.ref_request_pin(ref_request_pin),
		.ref_pulse_out(ref_pulse_out),
		.burst_busy(burst_busy)
	);

	// checks on the register behaviour
	logic rd_setup;
	assign rd_setup = setup && !pwrite;

	a_div_write_lands: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_en && sel_w[srr_pkg::SEL_DIV]) |=> (ref_pulse_divider == $past(pwdata[10:0])))
		else $error("divider write not stored");
	a_trim_write_lands: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_en && sel_w[srr_pkg::SEL_DLY_A]) |=>
		(delay_trim_one == $past(pwdata[5:0]) && delay_trim_two == $past(pwdata[11:6])))
		else $error("delay trim write not stored");
	a_burst_write_lands: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_en && sel_w[srr_pkg::SEL_DLY_B]) |=>
		(ref_burst_count == $past(pwdata[15:12]) && delay_trim_four == $past(pwdata[11:6])))
		else $error("burst count write not stored");
	a_channel_divider_select_write_lands: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_en && sel_w[srr_pkg::SEL_CHANNEL_DIVIDER_SELECT]) |=> (channel_divider_select == $past(pwdata[10:6])))
		else $error("channel divider write not stored");
	a_lock_read_value: assert property (@(posedge pclk) disable iff (!presetn)
		(rd_setup && sel_r[srr_pkg::SEL_LOCK]) |=>
		(prdata[10:9] == $past(lock_state_readback) && prdata[31:11] == '0 && prdata[8] == 1'b0))
		else $error("lock state readback wrong");
	a_cap_read_value: assert property (@(posedge pclk) disable iff (!presetn)
		(rd_setup && sel_r[srr_pkg::SEL_CAP]) |=> (prdata == {24'h000000, $past(osc_cap_readback)}))
		else $error("capacitor readback wrong");
	a_bias_read_value: assert property (@(posedge pclk) disable iff (!presetn)
		(rd_setup && sel_r[srr_pkg::SEL_BIAS]) |=> (prdata == {23'h000000, $past(osc_bias_readback)}))
		else $error("bias readback wrong");
	a_mode_read_value: assert property (@(posedge pclk) disable iff (!presetn)
		(rd_setup && sel_r[srr_pkg::SEL_MODE]) |=>
		(prdata[0] == $past(recal_pin_enable) && prdata[8:1] == $past(pin_mode_select)))
		else $error("mode pin readback wrong");
	a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
		(rd_setup && sel_r[srr_pkg::SEL_DIV]) |=> (prdata[31:11] == '0))
		else $error("reserved bits read nonzero");
	a_unmapped_error: assert property (@(posedge pclk) disable iff (!presetn)
		(setup && sel_r == '0) |=> (pslverr && prdata == '0))
		else $error("unmapped access not flagged");

	c_div_write: cover property (@(posedge pclk) disable iff (!presetn)
		wr_en && sel_w[srr_pkg::SEL_DIV]);
	c_lock_read: cover property (@(posedge pclk) disable iff (!presetn)
		rd_setup && sel_r[srr_pkg::SEL_LOCK] && lock_state_readback == 2'b10);
	c_unmapped: cover property (@(posedge pclk) disable iff (!presetn)
		pready && pslverr);
endmodule : srr_regs

// ==== srr_regs_tb.sv ====
// self-checking bench for the sysref and readback register slice
`timescale 1ns/10ps
module srr_regs_tb;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [1:0] lock_state_readback = 2'h0;
	logic [2:0] osc_core_readback = 3'h0;
	logic [7:0] osc_cap_readback = 8'h00;
	logic [8:0] osc_bias_readback = 9'h000;
	logic recal_pin_enable = 1'b0;
	logic [7:0] pin_mode_select = 8'h00;
	logic ref_request_pin = 1'b0;
	logic [10:0] ref_pulse_divider;
	logic [5:0] delay_trim_one, delay_trim_two, delay_trim_three, delay_trim_four;
	logic [3:0] ref_burst_count;
	logic [4:0] channel_divider_select;
	logic ref_repeater_select, ref_multi_pulse_enable, ref_pulse_out, burst_busy;
	int errors = 0;
	int checks = 0;
	int cyc = 0;
	int pulses = 0;
	int model[int];
	logic [7:0] rw_idx[5] = '{srr_pkg::IDX_CTRL, srr_pkg::IDX_DIV, srr_pkg::IDX_DLY_A,
		srr_pkg::IDX_DLY_B, srr_pkg::IDX_CHANNEL_DIVIDER_SELECT};
	logic [7:0] ro_idx[4] = '{srr_pkg::IDX_LOCK, srr_pkg::IDX_CAP, srr_pkg::IDX_BIAS,
		srr_pkg::IDX_MODE};

	srr_regs i_srr_regs (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .lock_state_readback(lock_state_readback),
		.osc_core_readback(osc_core_readback), .osc_cap_readback(osc_cap_readback),
		.osc_bias_readback(osc_bias_readback), .recal_pin_enable(recal_pin_enable),
		.pin_mode_select(pin_mode_select), .ref_request_pin(ref_request_pin),
		.ref_pulse_divider(ref_pulse_divider), .delay_trim_one(delay_trim_one),
		.delay_trim_two(delay_trim_two), .delay_trim_three(delay_trim_three),
		.delay_trim_four(delay_trim_four), .ref_burst_count(ref_burst_count),
		.channel_divider_select(channel_divider_select),
		.ref_repeater_select(ref_repeater_select),
		.ref_multi_pulse_enable(ref_multi_pulse_enable), .ref_pulse_out(ref_pulse_out),
		.burst_busy(burst_busy));

	// 50 mhz clock
	always #10 pclk = ~pclk;

	// pulse counter and hang guard; the ceiling is far above the planned run
	always @(posedge pclk) begin
		cyc++;
		if (ref_pulse_out === 1'b1) pulses++;
		if (cyc == 20000) begin
			errors++;
			end_of_test();
		end
	end

	task automatic end_of_test();
		$display("errors=%0d checks=%0d", errors, checks);
		if (errors == 0 && checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : end_of_test

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// writable bits of each register; everything else reads zero
	function automatic logic [31:0] rw_mask(input logic [7:0] idx);
		case (idx)
			srr_pkg::IDX_CTRL: return 32'h0000_0003;
			srr_pkg::IDX_DIV: return 32'h0000_07ff;
			srr_pkg::IDX_DLY_A: return 32'h0000_0fff;
			srr_pkg::IDX_DLY_B: return 32'h0000_ffff;
			srr_pkg::IDX_CHANNEL_DIVIDER_SELECT: return 32'h0000_07c0;
			default: return 32'h0000_0000;
		endcase
	endfunction : rw_mask

	// status registers mirror the inputs; others come from the write model
	function automatic logic [31:0] expect_rd(input logic [7:0] idx);
		case (idx)
			srr_pkg::IDX_LOCK: return {21'h0, lock_state_readback, 1'b0, osc_core_readback, 5'h00};
			srr_pkg::IDX_CAP: return {24'h0, osc_cap_readback};
			srr_pkg::IDX_BIAS: return {23'h0, osc_bias_readback};
			srr_pkg::IDX_MODE: return {23'h0, pin_mode_select, recal_pin_enable};
			default: return model.exists(idx) ? 32'(model[idx]) : 32'h0;
		endcase
	endfunction : expect_rd

	// one apb transfer; request held until pready is seen high at an edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic er);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		// no wait limit here: only the bench timeout ends a hung transfer
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [7:0] idx, input logic [31:0] d);
		logic [31:0] rd;
		logic er;
		apb(1'b1, {2'b00, idx, 2'b00}, d, rd, er);
		if (rw_mask(idx) != 32'h0) model[idx] = int'(d & rw_mask(idx));
		chk({31'h0, er}, 32'h0);
	endtask : wr

	task automatic rdc(input logic [7:0] idx);
		logic [31:0] rd;
		logic er;
		apb(1'b0, {2'b00, idx, 2'b00}, 32'h0, rd, er);
		chk(rd, expect_rd(idx));
		chk({31'h0, er}, 32'h0);
	endtask : rdc

	// raise the request pin once and count what comes out
	task automatic burst(input int want);
		int base;
		// let a pulse launched before the mode change be counted first
		@(posedge pclk);
		@(negedge pclk);
		base = pulses;
		@(posedge pclk);
		ref_request_pin <= 1'b1;
		repeat (40) @(posedge pclk);
		ref_request_pin <= 1'b0;
		repeat (4) @(posedge pclk);
		chk(32'(pulses - base), 32'(want));
		chk({31'h0, burst_busy}, 32'h0);
	endtask : burst

	initial begin
		logic [31:0] rd;
		logic er;
		int base;
		void'($urandom(89955));
		model[srr_pkg::IDX_CTRL] = 0;
		model[srr_pkg::IDX_DIV] = 1;
		model[srr_pkg::IDX_DLY_A] = 'h3f;
		model[srr_pkg::IDX_DLY_B] = 0;
		model[srr_pkg::IDX_CHANNEL_DIVIDER_SELECT] = 0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		// reset values of every writable register
		foreach (rw_idx[i]) rdc(rw_idx[i]);
		// random writes, reserved bits must stay zero
		for (int k = 0; k < 4; k++) begin
			foreach (rw_idx[i]) begin
				wr(rw_idx[i], $urandom);
				rdc(rw_idx[i]);
			end
		end
		chk({21'h0, ref_pulse_divider}, 32'(model[srr_pkg::IDX_DIV]));
		chk({20'h0, delay_trim_two, delay_trim_one}, 32'(model[srr_pkg::IDX_DLY_A]));
		chk({16'h0, ref_burst_count, delay_trim_four, delay_trim_three},
			32'(model[srr_pkg::IDX_DLY_B]));
		chk({21'h0, channel_divider_select, 6'h0}, 32'(model[srr_pkg::IDX_CHANNEL_DIVIDER_SELECT]));
		// every lock code, random status, writes to status ignored
		for (int c = 0; c < 4; c++) begin
			@(posedge pclk);
			lock_state_readback <= 2'(c);
			osc_core_readback <= 3'($urandom);
			osc_cap_readback <= 8'($urandom);
			osc_bias_readback <= 9'($urandom);
			recal_pin_enable <= 1'($urandom);
			pin_mode_select <= 8'($urandom);
			foreach (ro_idx[i]) begin
				wr(ro_idx[i], 32'hffff_ffff);
				rdc(ro_idx[i]);
			end
		end
		// unmapped and misaligned places answer with an error and zero
		apb(1'b0, 12'h140, 32'h0, rd, er);
		chk({er, rd[30:0]}, 32'h8000_0000);
		apb(1'b1, 12'h121, 32'h0000_07ff, rd, er);
		chk({31'h0, er}, 32'h1);
		rdc(srr_pkg::IDX_DIV);
		// repeater bursts: single pulse, counted burst, empty burst
		wr(srr_pkg::IDX_DIV, 32'h2);
		wr(srr_pkg::IDX_CTRL, 32'h1);
		burst(1);
		wr(srr_pkg::IDX_DLY_B, 32'h3000);
		wr(srr_pkg::IDX_CTRL, 32'h3);
		burst(3);
		wr(srr_pkg::IDX_DLY_B, 32'hf000);
		burst(15);
		wr(srr_pkg::IDX_DLY_B, 32'h0);
		burst(0);
		// free-running mode, one pulse per four cycles
		wr(srr_pkg::IDX_DIV, 32'h4);
		wr(srr_pkg::IDX_CTRL, 32'h0);
		repeat (8) @(posedge pclk);
		base = pulses;
		repeat (40) @(posedge pclk);
		chk({31'h0, (pulses - base) inside {[9:11]}}, 32'h1);
		end_of_test();
	end
endmodule : srr_regs_tb
